// *** logic/cfrbt_config.sv ***
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
module cfrbt_config (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRData,
   // Protocol engine side
   input wire cfrbt_pkg::cfrbt_recev_t recEvent,
   input wire logic otherBusOff,
   input wire cfrbt_pkg::cfrbt_idin_t idIn,
   input wire logic canRx,
   // Status and timing
   output logic errorPassive,
   output logic busOff,
   output cfrbt_pkg::cfrbt_timing_t timing,
   output logic tqTick,
   output logic wakeEvent,
   output logic acceptValid,
   output logic [cfrbt_pkg::FILT_IDX_W-1:0] acceptIdx,
   output logic irq
);
   localparam cfrbt_pkg::cfrbt_state_t RESET_STATE =
      '{cfgMode: 1'b1, tim: cfrbt_pkg::TIM_RESET, wake: cfrbt_pkg::WK_IDLE, default: '0};

   cfrbt_pkg::cfrbt_state_t q;
   cfrbt_pkg::cfrbt_state_t s;
   logic isFilt;
   logic isMask;
   logic [cfrbt_pkg::FILT_IDX_W-1:0] fIdx;
   logic [1:0] bSel;
   logic dominant;

   // Saturating add keeps the counter from wrapping to zero
   function automatic logic [7:0] satAdd(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] sum;
      sum = {1'b0, a} + {1'b0, b};
      satAdd = sum[8] ? cfrbt_pkg::REC_MAX : sum[7:0];
   endfunction

   // Segment field to length in quanta
   function automatic logic [3:0] segLen(input logic [2:0] f);
      segLen = {1'b0, f} + cfrbt_pkg::SEG_ONE;
   endfunction

   // Flatten an identifier group into 29 bits
   function automatic logic [cfrbt_pkg::ID_W-1:0] idFlat(input cfrbt_pkg::cfrbt_idreg_t r);
      idFlat = {r.sidh, r.sidl[cfrbt_pkg::SIDL_STD_MSB:cfrbt_pkg::SIDL_STD_LSB],
                r.sidl[cfrbt_pkg::SIDL_EXT_MSB:0], r.eidh, r.eidl};
   endfunction

   // One byte of an identifier group
   function automatic logic [7:0] idByte(input cfrbt_pkg::cfrbt_idreg_t r, input logic [1:0] sel);
      unique case (sel)
         cfrbt_pkg::BYTE_SIDH: idByte = r.sidh;
         cfrbt_pkg::BYTE_SIDL: idByte = r.sidl;
         cfrbt_pkg::BYTE_EIDH: idByte = r.eidh;
         cfrbt_pkg::BYTE_EIDL: idByte = r.eidl;
      endcase
   endfunction

   // Byte write; unimplemented low-byte bits are never stored
   function automatic cfrbt_pkg::cfrbt_idreg_t idWrite(input cfrbt_pkg::cfrbt_idreg_t r,
      input logic [1:0] sel, input logic [7:0] d, input logic [7:0] lowMask);
      idWrite = r;
      unique case (sel)
         cfrbt_pkg::BYTE_SIDH: idWrite.sidh = d;
         cfrbt_pkg::BYTE_SIDL: idWrite.sidl = d & lowMask;
         cfrbt_pkg::BYTE_EIDH: idWrite.eidh = d;
         cfrbt_pkg::BYTE_EIDL: idWrite.eidl = d;
      endcase
   endfunction

   // Acceptance test of one filter under the shared mask
   function automatic logic idMatch(input cfrbt_pkg::cfrbt_idreg_t f,
      input cfrbt_pkg::cfrbt_idreg_t m, input cfrbt_pkg::cfrbt_idin_t in);
      logic [cfrbt_pkg::ID_W-1:0] fv;
      logic [cfrbt_pkg::ID_W-1:0] mv;
      fv = idFlat(f);
      mv = idFlat(m);
      if (f.sidl[cfrbt_pkg::SIDL_EXT_SEL] != in.ext)
         idMatch = 1'b0;
      else if (in.ext)
         idMatch = ((fv ^ in.id) & mv) == '0;
      else
         idMatch = ((fv[cfrbt_pkg::ID_W-1 -: cfrbt_pkg::STD_ID_W]
                     ^ in.id[cfrbt_pkg::STD_ID_W-1:0])
                    & mv[cfrbt_pkg::ID_W-1 -: cfrbt_pkg::STD_ID_W]) == '0;
   endfunction

   // Address decode of the identifier groups
   assign isFilt = regAddr[cfrbt_pkg::ADDR_MSB:cfrbt_pkg::ADDR_GRP_LSB]
                   == cfrbt_pkg::ADDR_FILT_BASE[cfrbt_pkg::ADDR_MSB:cfrbt_pkg::ADDR_GRP_LSB];
   assign isMask = regAddr[cfrbt_pkg::ADDR_MSB:cfrbt_pkg::ADDR_IDX_BIT]
                   == cfrbt_pkg::ADDR_MASK_BASE[cfrbt_pkg::ADDR_MSB:cfrbt_pkg::ADDR_IDX_BIT];
   assign fIdx = regAddr[cfrbt_pkg::ADDR_IDX_BIT];
   assign bSel = regAddr[1:0];
   assign dominant = ~canRx;

   // Next state of the whole block
   always_comb
   begin
      s = q;
      s.rdData = 8'h00;
      s.tqTick = 1'b0;
      s.wakePulse = 1'b0;
      s.hit = 1'b0;
      // Software writes
      if (regWr)
      begin
         if (regAddr == cfrbt_pkg::ADDR_CTRL)
            s.cfgMode = regWData[cfrbt_pkg::CTRL_CFG_BIT];
         else if (regAddr == cfrbt_pkg::ADDR_IRQ_MASK)
            s.irqMask = regWData[cfrbt_pkg::IRQ_W-1:0];
         else if (regAddr == cfrbt_pkg::ADDR_BT1 && q.cfgMode)
            s.bt1 = regWData;
         else if (regAddr == cfrbt_pkg::ADDR_BT2 && q.cfgMode)
            s.bt2 = regWData;
         else if (regAddr == cfrbt_pkg::ADDR_BT3)
            s.bt3 = regWData & cfrbt_pkg::BT3_WMASK;
         else if (isFilt)
            s.filt[fIdx] = idWrite(q.filt[fIdx], bSel, regWData,
                                   cfrbt_pkg::FILT_SIDL_WMASK);
         else if (isMask)
            s.mask = idWrite(q.mask, bSel, regWData,
                             cfrbt_pkg::MASK_SIDL_WMASK);
      end
      // Software reads; unmapped addresses answer zero
      if (regRd)
      begin
         if (regAddr == cfrbt_pkg::ADDR_REC)
            s.rdData = q.rec;
         else if (regAddr == cfrbt_pkg::ADDR_CTRL)
            s.rdData = {7'h00, q.cfgMode};
         else if (regAddr == cfrbt_pkg::ADDR_IRQ_STAT)
            s.rdData = {5'h00, q.irqStat};
         else if (regAddr == cfrbt_pkg::ADDR_IRQ_MASK)
            s.rdData = {5'h00, q.irqMask};
         else if (regAddr == cfrbt_pkg::ADDR_BT1)
            s.rdData = q.bt1;
         else if (regAddr == cfrbt_pkg::ADDR_BT2)
            s.rdData = q.bt2;
         else if (regAddr == cfrbt_pkg::ADDR_BT3)
            s.rdData = q.bt3;
         else if (isFilt)
            s.rdData = idByte(q.filt[fIdx], bSel);
         else if (isMask)
            s.rdData = idByte(q.mask, bSel);
      end
      // Receive error counter; big step beats small step beats recovery
      if (recEvent.inc8)
         s.rec = satAdd(q.rec, cfrbt_pkg::REC_STEP_BIG);
      else if (recEvent.inc1)
         s.rec = satAdd(q.rec, cfrbt_pkg::REC_STEP_ERR);
      else if (recEvent.rxOk)
      begin
         if (q.rec > cfrbt_pkg::REC_PASSIVE_LIMIT)
            s.rec = cfrbt_pkg::REC_RECOVER;
         else if (q.rec != 8'h00)
            s.rec = q.rec - cfrbt_pkg::REC_STEP_ERR;
      end
      s.passive = s.rec > cfrbt_pkg::REC_PASSIVE_LIMIT;
      // Bus-off comes only from the other error sources
      s.busOff = otherBusOff;
      // Decoded timing, one cycle behind the registers
      s.tim.sjw = {1'b0, q.bt1[cfrbt_pkg::SJW_MSB:cfrbt_pkg::SJW_LSB]} + cfrbt_pkg::SJW_ONE;
      s.tim.tqCycles = {1'b0, q.bt1[cfrbt_pkg::BRP_MSB:0], 1'b0} + cfrbt_pkg::TQ_STEP;
      s.tim.ph1 = segLen(q.bt2[cfrbt_pkg::PH1_MSB:cfrbt_pkg::PH1_LSB]);
      s.tim.prop = segLen(q.bt2[cfrbt_pkg::SEG_MSB:0]);
      if (q.bt2[cfrbt_pkg::PH2_SEL_BIT])
         s.tim.ph2 = segLen(q.bt3[cfrbt_pkg::SEG_MSB:0]);
      else
         s.tim.ph2 = (s.tim.ph1 > cfrbt_pkg::PROC_TIME_QUANTA) ? s.tim.ph1
                     : cfrbt_pkg::PROC_TIME_QUANTA;
      s.tim.triple = q.bt2[cfrbt_pkg::SAMPLE3_BIT];
      s.tim.wakeFilt = q.bt3[cfrbt_pkg::WAKE_FILT_BIT];
      // Quantum generator; held in configuration so a new prescaler starts clean
      if (q.cfgMode)
         s.tqCnt = 8'h00;
      else if (q.tqCnt >= q.tim.tqCycles - cfrbt_pkg::TQ_CNT_ONE)
      begin
         s.tqCnt = 8'h00;
         s.tqTick = 1'b1;
      end
      else
         s.tqCnt = q.tqCnt + cfrbt_pkg::TQ_CNT_ONE;
      // Wake-up detector; the filter rejects short dominant glitches
      unique case (q.wake)
         cfrbt_pkg::WK_IDLE:
            if (dominant)
            begin
               if (q.tim.wakeFilt)
               begin
                  s.wake = cfrbt_pkg::WK_FILTER;
                  s.wakeCnt = cfrbt_pkg::WAKE_CNT_ONE;
               end
               else
               begin
                  s.wake = cfrbt_pkg::WK_ACTIVE;
                  s.wakePulse = 1'b1;
               end
            end
         cfrbt_pkg::WK_FILTER:
            if (!dominant)
               s.wake = cfrbt_pkg::WK_IDLE;
            else if (q.wakeCnt >= cfrbt_pkg::WAKE_CNT_LAST)
            begin
               s.wake = cfrbt_pkg::WK_ACTIVE;
               s.wakePulse = 1'b1;
            end
            else
               s.wakeCnt = q.wakeCnt + cfrbt_pkg::WAKE_CNT_ONE;
         cfrbt_pkg::WK_ACTIVE:
            if (!dominant)
               s.wake = cfrbt_pkg::WK_IDLE;
         default:
            s.wake = cfrbt_pkg::WK_IDLE;
      endcase
      // Acceptance; descending loop lets the lowest filter win
      if (idIn.valid)
      begin
         for (int i = cfrbt_pkg::NUM_FILT - 1; i >= 0; i--)
         begin
            if (idMatch(q.filt[i], q.mask, idIn))
            begin
               s.hit = 1'b1;
               s.hitIdx = i[cfrbt_pkg::FILT_IDX_W-1:0];
            end
         end
      end
      // Sticky status; a set in the clearing read's cycle survives
      if (regRd && regAddr == cfrbt_pkg::ADDR_IRQ_STAT)
         s.irqStat = '0;
      s.irqStat[cfrbt_pkg::IRQ_ACCEPT] = s.irqStat[cfrbt_pkg::IRQ_ACCEPT] | s.hit;
      s.irqStat[cfrbt_pkg::IRQ_WAKE] = s.irqStat[cfrbt_pkg::IRQ_WAKE] | s.wakePulse;
      s.irqStat[cfrbt_pkg::IRQ_PASSIVE] = s.irqStat[cfrbt_pkg::IRQ_PASSIVE]
                                          | (s.passive & ~q.passive);
   end

   // State register
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         q <= RESET_STATE;
      else
         q <= s;
   end

   // Outputs straight from the state
   assign regRData = q.rdData;
   assign errorPassive = q.passive;
   assign busOff = q.busOff;
   assign timing = q.tim;
   assign tqTick = q.tqTick;
   assign wakeEvent = q.wakePulse;
   assign acceptValid = q.hit;
   assign acceptIdx = q.hitIdx;
   assign irq = |(q.irqStat & q.irqMask);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Passive flag tracks the count
   a_passive_level: assert property (errorPassive == (q.rec > cfrbt_pkg::REC_PASSIVE_LIMIT))
      else $error("passive flag disagrees with count");
   a_rec_step_big: assert property (recEvent.inc8 && q.rec < 8'hF0 |=> q.rec == $past(q.rec) + 8'h08)
      else $error("count did not rise by eight");
   a_busoff_source: assert property (!otherBusOff |=> !busOff)
      else $error("bus-off without outside cause");
   a_timing_lock: assert property (regWr && regAddr == cfrbt_pkg::ADDR_BT1 && !q.cfgMode |=> $stable(q.bt1))
      else $error("timing register changed outside configuration");
   a_sjw_decode: assert property (q.bt1[7:6] == 2'h3 ##1 $stable(q.bt1) |-> timing.sjw == 3'h4)
      else $error("jump width decode wrong");
   a_tq_decode: assert property ($stable(q.bt1) |=> timing.tqCycles == {1'b0, $past(q.bt1[5:0]), 1'b0} + 8'h02)
      else $error("quantum length decode wrong");
   a_ph2_auto: assert property (!q.bt2[7] && $stable(q.bt2) |=> timing.ph2 >= timing.ph1 && timing.ph2 >= 4'h2)
      else $error("automatic phase two too short");
   a_flt_lowbits: assert property (regRd && isFilt && bSel == cfrbt_pkg::BYTE_SIDL |=> (regRData & 8'h14) == 8'h00)
      else $error("filter low byte reserved bits set");
   a_mask_lowbits: assert property (regRd && isMask && bSel == cfrbt_pkg::BYTE_SIDL |=> (regRData & 8'h1C) == 8'h00)
      else $error("mask low byte reserved bits set");
   a_ext_select: assert property (acceptValid |-> q.filt[acceptIdx].sidl[3] == $past(idIn.ext))
      else $error("accepted frame of wrong identifier kind");
   a_wake_direct: assert property (q.wake == cfrbt_pkg::WK_IDLE && !q.tim.wakeFilt && !canRx |=> wakeEvent)
      else $error("unfiltered wake not seen");
   a_wake_filter: assert property (q.wake == cfrbt_pkg::WK_IDLE && q.tim.wakeFilt && !canRx |=> !wakeEvent [*4])
      else $error("filtered wake too early");

   // No quantum ticks while the prescaler may still be rewritten
   a_tick_config: assert property (q.cfgMode |=> !tqTick)
      else $error("quantum tick in configuration mode");
   a_busoff_follow: assert property (otherBusOff |=> busOff)
      else $error("bus-off cause not passed on");
   a_ph2_program: assert property (q.bt2[7] && $stable(q.bt2) && $stable(q.bt3) |=> timing.ph2 == {1'b0, $past(q.bt3[2:0])} + 4'h1)
      else $error("programmed phase two decode wrong");
   a_rec_readonly: assert property (regWr && regAddr == cfrbt_pkg::ADDR_REC && recEvent == '0 |=> q.rec == $past(q.rec))
      else $error("error count changed by a write");

   c_accept: cover property (acceptValid);
   c_wake_filt: cover property (wakeEvent && q.tim.wakeFilt);
   c_passive: cover property (!errorPassive ##1 errorPassive);
   c_irq: cover property (irq);
endmodule
`default_nettype wire

// *** logic/cfrbt_pkg.sv ***
`default_nettype none
package cfrbt_pkg;
   // Register map, one byte per address
   localparam logic [7:0] ADDR_REC = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h01;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h02;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h03;
   localparam logic [7:0] ADDR_BT1 = 8'h08;
   localparam logic [7:0] ADDR_BT2 = 8'h09;
   localparam logic [7:0] ADDR_BT3 = 8'h0A;
   localparam logic [7:0] ADDR_FILT_BASE = 8'h10;
   localparam logic [7:0] ADDR_MASK_BASE = 8'h20;
   localparam int ADDR_MSB = 7;
   localparam int ADDR_GRP_LSB = 3;
   localparam int ADDR_IDX_BIT = 2;
   localparam int NUM_FILT = 2;
   localparam int FILT_IDX_W = 1;
   // Byte select inside an identifier group
   localparam logic [1:0] BYTE_SIDH = 2'h0;
   localparam logic [1:0] BYTE_SIDL = 2'h1;
   localparam logic [1:0] BYTE_EIDH = 2'h2;
   localparam logic [1:0] BYTE_EIDL = 2'h3;
   // Writable bits of the mixed registers
   localparam logic [7:0] FILT_SIDL_WMASK = 8'hEB;
   localparam logic [7:0] MASK_SIDL_WMASK = 8'hE3;
   localparam logic [7:0] BT3_WMASK = 8'h47;
   localparam logic [7:0] BYTE_ALL = 8'hFF;
   // Field positions
   localparam int SIDL_STD_MSB = 7;
   localparam int SIDL_STD_LSB = 5;
   localparam int SIDL_EXT_SEL = 3;
   localparam int SIDL_EXT_MSB = 1;
   localparam int ID_W = 29;
   localparam int STD_ID_W = 11;
   localparam int CTRL_CFG_BIT = 0;
   localparam int SJW_MSB = 7;
   localparam int SJW_LSB = 6;
   localparam int BRP_MSB = 5;
   localparam int PH2_SEL_BIT = 7;
   localparam int SAMPLE3_BIT = 6;
   localparam int PH1_MSB = 5;
   localparam int PH1_LSB = 3;
   localparam int SEG_MSB = 2;
   localparam int WAKE_FILT_BIT = 6;
   localparam int IRQ_ACCEPT = 0;
   localparam int IRQ_WAKE = 1;
   localparam int IRQ_PASSIVE = 2;
   localparam int IRQ_W = 3;
   // Receive error counter
   localparam logic [7:0] REC_PASSIVE_LIMIT = 8'h7F;
   localparam logic [7:0] REC_STEP_ERR = 8'h01;
   localparam logic [7:0] REC_STEP_BIG = 8'h08;
   localparam logic [7:0] REC_RECOVER = 8'h77;
   localparam logic [7:0] REC_MAX = 8'hFF;
   // Timing
   localparam logic [3:0] SEG_ONE = 4'h1;
   localparam logic [2:0] SJW_ONE = 3'h1;
   localparam logic [7:0] TQ_STEP = 8'h02;
   localparam logic [7:0] TQ_CNT_ONE = 8'h01;
   localparam logic [3:0] PROC_TIME_QUANTA = 4'h2;
   localparam int CLK_PERIOD_NS = 40;
   localparam int WAKE_FILTER_NS = 200;
   localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] WAKE_CNT_LAST = 3'(WAKE_FILTER_CYC - 1);
   localparam logic [2:0] WAKE_CNT_ONE = 3'h1;

   typedef enum logic [1:0] {WK_IDLE = 2'b00, WK_FILTER = 2'b01, WK_ACTIVE = 2'b11} cfrbt_wake_t;
   typedef struct packed {logic [7:0] sidh; logic [7:0] sidl; logic [7:0] eidh; logic [7:0] eidl;}
      cfrbt_idreg_t;
   typedef struct packed {logic inc1; logic inc8; logic rxOk;} cfrbt_recev_t;
   typedef struct packed {logic [ID_W-1:0] id; logic ext; logic valid;} cfrbt_idin_t;
   typedef struct packed {
      logic [2:0] sjw;
      logic [7:0] tqCycles;
      logic [3:0] prop;
      logic [3:0] ph1;
      logic [3:0] ph2;
      logic triple;
      logic wakeFilt;
   } cfrbt_timing_t;
   localparam cfrbt_timing_t TIM_RESET = '{SJW_ONE, TQ_STEP, SEG_ONE, SEG_ONE, PROC_TIME_QUANTA,
                                          1'b0, 1'b0};
   typedef struct packed {
      logic [7:0] rec;
      logic passive;
      logic busOff;
      cfrbt_idreg_t [NUM_FILT-1:0] filt;
      cfrbt_idreg_t mask;
      logic [7:0] bt1;
      logic [7:0] bt2;
      logic [7:0] bt3;
      logic cfgMode;
      logic [IRQ_W-1:0] irqStat;
      logic [IRQ_W-1:0] irqMask;
      logic [7:0] rdData;
      cfrbt_timing_t tim;
      logic [7:0] tqCnt;
      logic tqTick;
      cfrbt_wake_t wake;
      logic [2:0] wakeCnt;
      logic wakePulse;
      logic hit;
      logic [FILT_IDX_W-1:0] hitIdx;
   } cfrbt_state_t;
endpackage
`default_nettype wire

// *** verification/cfrbt_bus_node.sv ***
`timescale 1ns/10ps
`default_nettype none
module cfrbt_bus_node (
   // Clock
   input wire logic clk,
   // Toward the configuration block
   output var cfrbt_pkg::cfrbt_recev_t recEvent,
   output var logic otherBusOff,
   output var cfrbt_pkg::cfrbt_idin_t idIn,
   output var logic canRx
);
   // Bus starts recessive with nothing pending
   initial
   begin
      recEvent = '0;
      otherBusOff = 1'b0;
      idIn = '0;
      canRx = 1'b1;
   end
   // Error events on n consecutive cycles
   task automatic errEvents(input logic [2:0] ev, input int n);
      repeat (n)
      begin
         @(posedge clk);
         recEvent <= ev;
      end
      @(posedge clk);
      recEvent <= '0;
   endtask
   // One candidate identifier; afterwards the id lines are scrambled, never left stale
   task automatic sendId(input logic [28:0] id, input logic ext);
      @(posedge clk);
      idIn <= '{id, ext, 1'b1};
      @(posedge clk);
      idIn <= '{~id, ~ext, 1'b0};
   endtask
   // Bus-off cause from the other error sources, a level
   task automatic setBusOff(input logic v);
      otherBusOff <= v;
   endtask
   // Dominant level seen at exactly n sampling edges, then recessive again
   task automatic dominant(input int n);
      @(posedge clk);
      canRx <= 1'b0;
      repeat (n) @(posedge clk);
      canRx <= 1'b1;
   endtask
endmodule
`default_nettype wire

// *** verification/cfrbt_config_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module cfrbt_config_tb;
   logic clk, rst_b, regWr, regRd, otherBusOff, canRx, errorPassive, busOff, tqTick;
   logic wakeEvent, acceptValid, irq;
   logic [7:0] regAddr, regWData, regRData;
   logic [cfrbt_pkg::FILT_IDX_W-1:0] acceptIdx;
   cfrbt_pkg::cfrbt_recev_t recEvent;
   cfrbt_pkg::cfrbt_idin_t idIn;
   cfrbt_pkg::cfrbt_timing_t timing;
   int miscompares, cmpCount, wakeCnt, n, i;
   localparam logic [28:0] ID_S = 29'h000005A3;
   localparam logic [28:0] ID_E = 29'h1ABCDEF5;
   logic [7:0] rwAddr [13] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
      8'h20, 8'h21, 8'h22, 8'h23, 8'h0A};
   logic [7:0] rwExp [13] = '{8'hFF, 8'hEB, 8'hFF, 8'hFF, 8'hFF, 8'hEB, 8'hFF, 8'hFF,
      8'hFF, 8'hE3, 8'hFF, 8'hFF, 8'h47};
   logic [7:0] rsAddr [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h09, 8'h30};
   logic [7:0] rsExp [7] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   cfrbt_config i_cfrbt_config (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
      .regWData(regWData), .regWr(regWr), .regRd(regRd), .regRData(regRData),
      .recEvent(recEvent), .otherBusOff(otherBusOff), .idIn(idIn), .canRx(canRx),
      .errorPassive(errorPassive), .busOff(busOff), .timing(timing), .tqTick(tqTick),
      .wakeEvent(wakeEvent), .acceptValid(acceptValid), .acceptIdx(acceptIdx), .irq(irq));
   cfrbt_bus_node i_cfrbt_bus_node (.clk(clk), .recEvent(recEvent),
      .otherBusOff(otherBusOff), .idIn(idIn), .canRx(canRx));

   // 25 MHz clock
   initial clk = 1'b0;
   always #20 clk = ~clk;
   // Wake pulses are counted so a doubled or missing pulse shows up
   always @(negedge clk) if (wakeEvent === 1'b1) wakeCnt++;

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", cmpCount, miscompares);
      if (miscompares == 0 && cmpCount > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // One-cycle write strobe; the next access waits for a fresh edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(regRData, exp);
   endtask
   task automatic tim(input cfrbt_pkg::cfrbt_timing_t exp);
      repeat (2) @(posedge clk);
      #1 chk(timing, exp);
   endtask
   task automatic acc(input logic [28:0] id, input logic ext, input logic hit, input logic idx);
      i_cfrbt_bus_node.sendId(id, ext);
      #1 chk(acceptValid, hit);
      if (hit) chk(acceptIdx, idx);
   endtask
   task automatic waitTick();
      n = 0;
      do
      begin
         @(posedge clk);
         #1 n++;
      end
      while (tqTick !== 1'b1 && n < 300);
   endtask

   // Watchdog well beyond the few hundred cycles the sequence needs
   initial
   begin
      #(40 * 20000);
      miscompares++;
      end_sim();
   end

   // Main sequence
   initial
   begin
      rst_b = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 8'h00;
      regWData = 8'h00;
      miscompares = 0;
      cmpCount = 0;
      wakeCnt = 0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      #1 chk(timing, cfrbt_pkg::TIM_RESET);
      chk(irq, 1'b0);
      for (i = 0; i < 7; i++) rd(rsAddr[i], rsExp[i]);
      for (i = 0; i < 13; i++)
      begin
         rd(rwAddr[i], 8'h00);
         wr(rwAddr[i], 8'hFF);
         rd(rwAddr[i], rwExp[i]);
      end
      // Bit timing, written while still in configuration mode
      wr(8'h08, 8'hFF);
      wr(8'h09, 8'hBA);
      wr(8'h0A, 8'h45);
      tim('{3'h4, 8'h80, 4'h3, 4'h8, 4'h6, 1'b0, 1'b1});
      wr(8'h09, 8'h50);
      tim('{3'h4, 8'h80, 4'h1, 4'h3, 4'h3, 1'b1, 1'b1});
      wr(8'h09, 8'h40);
      tim('{3'h4, 8'h80, 4'h1, 4'h1, 4'h2, 1'b1, 1'b1});
      // Leave configuration mode: BT1 and BT2 locked, quantum ticks run
      wr(8'h01, 8'h00);
      wr(8'h08, 8'h00);
      wr(8'h09, 8'h00);
      rd(8'h08, 8'hFF);
      rd(8'h09, 8'h40);
      waitTick();
      waitTick();
      chk(n, 128);
      // Acceptance: filter 0 standard, filter 1 extended, full mask
      wr(8'h10, ID_S[10:3]);
      wr(8'h11, {ID_S[2:0], 5'h00});
      wr(8'h14, ID_E[28:21]);
      wr(8'h15, {ID_E[20:18], 3'b010, ID_E[17:16]});
      wr(8'h16, ID_E[15:8]);
      wr(8'h17, ID_E[7:0]);
      acc(ID_S, 1'b0, 1'b1, 1'b0);
      acc(ID_S, 1'b1, 1'b0, 1'b0);
      acc(ID_E, 1'b1, 1'b1, 1'b1);
      acc(ID_E, 1'b0, 1'b0, 1'b0);
      acc(ID_S ^ 29'h1, 1'b0, 1'b0, 1'b0);
      acc(ID_E ^ 29'h1, 1'b1, 1'b0, 1'b0);
      wr(8'h23, 8'hFE);
      acc(ID_E ^ 29'h1, 1'b1, 1'b1, 1'b1);
      chk(irq, 1'b0);
      wr(8'h03, 8'h01);
      #1 chk(irq, 1'b1);
      rd(8'h02, 8'h01);
      chk(irq, 1'b0);
      rd(8'h02, 8'h00);
      // Receive error count around the passive threshold
      i_cfrbt_bus_node.errEvents(3'h2, 15);
      i_cfrbt_bus_node.errEvents(3'h4, 7);
      rd(8'h00, 8'h7F);
      chk(errorPassive, 1'b0);
      i_cfrbt_bus_node.errEvents(3'h4, 1);
      rd(8'h00, 8'h80);
      chk(errorPassive, 1'b1);
      chk(busOff, 1'b0);
      rd(8'h02, 8'h04);
      i_cfrbt_bus_node.errEvents(3'h1, 1);
      rd(8'h00, 8'h77);
      chk(errorPassive, 1'b0);
      i_cfrbt_bus_node.errEvents(3'h1, 1);
      rd(8'h00, 8'h76);
      i_cfrbt_bus_node.errEvents(3'h2, 40);
      wr(8'h00, 8'h00);
      rd(8'h00, 8'hFF);
      chk(busOff, 1'b0);
      i_cfrbt_bus_node.setBusOff(1'b1);
      repeat (2) @(posedge clk);
      #1 chk(busOff, 1'b1);
      i_cfrbt_bus_node.setBusOff(1'b0);
      // Wake-up through the line filter, then without it
      i_cfrbt_bus_node.dominant(4);
      repeat (3) @(posedge clk);
      chk(wakeCnt, 0);
      i_cfrbt_bus_node.dominant(5);
      repeat (3) @(posedge clk);
      chk(wakeCnt, 1);
      wr(8'h0A, 8'h05);
      i_cfrbt_bus_node.dominant(1);
      repeat (3) @(posedge clk);
      chk(wakeCnt, 2);
      rd(8'h02, 8'h06);
      end_sim();
   end
endmodule
`default_nettype wire
